/* mwm_consts.svh */
/*
 * Constant macros of the motion window monitor: object indices, reset values,
 * status bit positions, mode codes and the millisecond tick count.
 * Assumes a 50 MHz system clock; included by bare name.
 */
`ifndef MWM_CONSTS_SVH
`define MWM_CONSTS_SVH

// ****************************************************************
// Object indices
// ****************************************************************
`define MWM_IDX_ACTUAL_POSITION      16'h6064
`define MWM_IDX_LAG_LIMIT            16'h6065
`define MWM_IDX_LAG_DWELL_MS         16'h6066
`define MWM_IDX_TARGET_BAND          16'h6067
`define MWM_IDX_TARGET_BAND_DWELL_MS 16'h6068
`define MWM_IDX_RAMP_SPEED_OUTPUT    16'h606B
`define MWM_IDX_MEASURED_SPEED       16'h606C
`define MWM_IDX_SPEED_BAND           16'h606D
`define MWM_IDX_SPEED_BAND_DWELL_MS  16'h606E

// ****************************************************************
// Reset values
// ****************************************************************
`define MWM_RST_LAG_LIMIT            32'h00000100
`define MWM_RST_LAG_DWELL_MS         16'h0064
`define MWM_RST_TARGET_BAND          32'h0000000A
`define MWM_RST_TARGET_BAND_DWELL_MS 16'h0064
`define MWM_RST_SPEED_BAND           16'h001E
`define MWM_RST_SPEED_BAND_DWELL_MS  16'h0000
`define MWM_WINDOW_OFF               32'hFFFFFFFF

// ****************************************************************
// Status bits and operating modes
// ****************************************************************
`define MWM_SW_TARGET_BIT            4'hA
`define MWM_SW_LAG_BIT               4'hD
`define MWM_MODE_PROFILE_POS         8'h01
`define MWM_MODE_PROFILE_VEL         8'h03
`define MWM_MODE_INTERP_POS          8'h07

// ****************************************************************
// Timing
// ****************************************************************
`define MWM_CLK_HZ                   50000000
`define MWM_TICK_MS                  1
`define MWM_TICK_CYCLES              ((`MWM_CLK_HZ / 1000) * `MWM_TICK_MS)

`endif

/* mwm_pkg.sv */
/*
 * Types shared by the motion window monitor modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mwm_pkg;

    // Object access request from the fieldbus object dictionary
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] index;
        logic [31:0] wdata;
    } mwm_obj_req_s;

    // Live drive values sampled every clock
    typedef struct packed {
        logic [31:0] demand_position;
        logic [31:0] actual_position;
        logic [31:0] target_position;
        logic [31:0] ramp_speed;
        logic [31:0] set_speed;
        logic [31:0] measured_speed;
    } mwm_drive_s;

    typedef enum logic [1:0] {
        MWM_DW_IDLE  = 2'b00,
        MWM_DW_COUNT = 2'b01,
        MWM_DW_MET   = 2'b10
    } mwm_dwell_e;

endpackage : mwm_pkg

/* mwm_tick.sv */
/*
 * Millisecond enable divider.
 * Assumes one synchronous clock; emits a one-cycle pulse every CYCLES clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module mwm_tick
    import mwm_pkg::*;
#(
    parameter int CYCLES = 50000
) (
    input  wire logic clk,
    input  wire logic rstn,
    output logic      tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        tick_r;
    logic        tick_nxt;

    // ****************************************************************
    // Divider
    // ****************************************************************
    always_comb begin
        tick_nxt = 1'b0;
        cnt_nxt  = cnt_r + 32'h00000001;
        if (cnt_r == 32'(CYCLES - 1)) begin
            cnt_nxt  = 32'h00000000;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_r  <= 32'h00000000;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule : mwm_tick
`default_nettype wire

/* mwm_dwell.sv */
/*
 * Dwell qualifier: output rises once the condition has held for more than
 * limit milliseconds. Assumes a one-cycle millisecond tick from mwm_tick.
 */
`timescale 1ns/100ps
`default_nettype none
module mwm_dwell
    import mwm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        tick,
    input  wire logic        cond,
    input  wire logic [15:0] limit,
    output logic             met
);
    mwm_dwell_e  st_r;
    mwm_dwell_e  st_nxt;
    logic [16:0] ms_r;
    logic [16:0] ms_nxt;

    // ****************************************************************
    // Dwell state machine
    // ****************************************************************
    // Counter is one bit wider so a limit of FFFF still terminates
    always_comb begin
        st_nxt = st_r;
        ms_nxt = ms_r;
        case (st_r)
            MWM_DW_IDLE: begin
                ms_nxt = 17'h00000;
                if (cond) begin
                    st_nxt = MWM_DW_COUNT;
                end
            end
            MWM_DW_COUNT: begin
                if (!cond) begin
                    st_nxt = MWM_DW_IDLE;
                    ms_nxt = 17'h00000;
                end else if (ms_r > {1'b0, limit}) begin
                    st_nxt = MWM_DW_MET;
                end else if (tick) begin
                    ms_nxt = ms_r + 17'h00001;
                end
            end
            MWM_DW_MET: begin
                if (!cond) begin
                    st_nxt = MWM_DW_IDLE;
                    ms_nxt = 17'h00000;
                end
            end
            default: begin
                st_nxt = MWM_DW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r <= MWM_DW_IDLE;
            ms_r <= 17'h00000;
        end else begin
            st_r <= st_nxt;
            ms_r <= ms_nxt;
        end
    end

    assign met = (st_r == MWM_DW_MET);
endmodule : mwm_dwell
`default_nettype wire

/* mwm_top.sv */
/*
 * Motion window monitor: following error, position reached and velocity
 * reached supervision with millisecond dwell, plus the related objects.
 * Assumes the object dictionary delivers one-cycle rd/wr strobes with an
 * object index, and that drive values are synchronous to clk.
 */
`include "mwm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module mwm_top
    import mwm_pkg::*;
#(
    parameter int TICK_CYCLES = `MWM_TICK_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire mwm_obj_req_s obj_req,
    input  wire mwm_drive_s   drive,
    input  wire logic [7:0]   op_mode,
    input  wire logic [15:0]  lag_reaction,
    output logic [31:0]       obj_rdata,
    output logic              obj_ack,
    output logic              obj_err,
    output logic [15:0]       status_bits,
    output logic              lag_reaction_req,
    output logic              history_log,
    output logic [31:0]       actual_position,
    output logic [31:0]       ramp_speed_output,
    output logic signed [31:0] measured_speed
);
    // ****************************************************************
    // Configuration objects
    // ****************************************************************
    logic [31:0] lag_limit_r,            lag_limit_nxt;
    logic [15:0] lag_dwell_ms_r,         lag_dwell_ms_nxt;
    logic [31:0] target_band_r,          target_band_nxt;
    logic [15:0] target_band_dwell_ms_r, target_band_dwell_ms_nxt;
    logic [15:0] speed_band_r,           speed_band_nxt;
    logic [15:0] speed_band_dwell_ms_r,  speed_band_dwell_ms_nxt;
    logic [31:0] rdata_r,                rdata_nxt;
    logic        ack_r,                  ack_nxt;
    logic        err_r,                  err_nxt;

    // Signed difference magnitude, unsigned result
    function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] d;
        d = {a[31], a} - {b[31], b};
        abs_diff = d[32] ? 32'(-d) : d[31:0];
    endfunction : abs_diff

    // Object read and write decoding
    always_comb begin
        lag_limit_nxt            = lag_limit_r;
        lag_dwell_ms_nxt         = lag_dwell_ms_r;
        target_band_nxt          = target_band_r;
        target_band_dwell_ms_nxt = target_band_dwell_ms_r;
        speed_band_nxt           = speed_band_r;
        speed_band_dwell_ms_nxt  = speed_band_dwell_ms_r;
        rdata_nxt                = rdata_r;
        ack_nxt                  = obj_req.rd | obj_req.wr;
        err_nxt                  = 1'b0;
        if (obj_req.wr) begin
            // Read-only objects refuse writes and keep their value
            if (obj_req.index == `MWM_IDX_LAG_LIMIT) begin
                lag_limit_nxt = obj_req.wdata;
            end else if (obj_req.index == `MWM_IDX_LAG_DWELL_MS) begin
                lag_dwell_ms_nxt = obj_req.wdata[15:0];
            end else if (obj_req.index == `MWM_IDX_TARGET_BAND) begin
                target_band_nxt = obj_req.wdata;
            end else if (obj_req.index == `MWM_IDX_TARGET_BAND_DWELL_MS) begin
                target_band_dwell_ms_nxt = obj_req.wdata[15:0];
            end else if (obj_req.index == `MWM_IDX_SPEED_BAND) begin
                speed_band_nxt = obj_req.wdata[15:0];
            end else if (obj_req.index == `MWM_IDX_SPEED_BAND_DWELL_MS) begin
                speed_band_dwell_ms_nxt = obj_req.wdata[15:0];
            end else begin
                err_nxt = 1'b1;
            end
        end else if (obj_req.rd) begin
            if (obj_req.index == `MWM_IDX_ACTUAL_POSITION) begin
                rdata_nxt = drive.actual_position;
            end else if (obj_req.index == `MWM_IDX_LAG_LIMIT) begin
                rdata_nxt = lag_limit_r;
            end else if (obj_req.index == `MWM_IDX_LAG_DWELL_MS) begin
                rdata_nxt = {16'h0000, lag_dwell_ms_r};
            end else if (obj_req.index == `MWM_IDX_TARGET_BAND) begin
                rdata_nxt = target_band_r;
            end else if (obj_req.index == `MWM_IDX_TARGET_BAND_DWELL_MS) begin
                rdata_nxt = {16'h0000, target_band_dwell_ms_r};
            end else if (obj_req.index == `MWM_IDX_RAMP_SPEED_OUTPUT) begin
                rdata_nxt = drive.ramp_speed;
            end else if (obj_req.index == `MWM_IDX_MEASURED_SPEED) begin
                rdata_nxt = drive.measured_speed;
            end else if (obj_req.index == `MWM_IDX_SPEED_BAND) begin
                rdata_nxt = {16'h0000, speed_band_r};
            end else if (obj_req.index == `MWM_IDX_SPEED_BAND_DWELL_MS) begin
                rdata_nxt = {16'h0000, speed_band_dwell_ms_r};
            end else begin
                rdata_nxt = 32'h00000000;
                err_nxt   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            lag_limit_r            <= `MWM_RST_LAG_LIMIT;
            lag_dwell_ms_r         <= `MWM_RST_LAG_DWELL_MS;
            target_band_r          <= `MWM_RST_TARGET_BAND;
            target_band_dwell_ms_r <= `MWM_RST_TARGET_BAND_DWELL_MS;
            speed_band_r           <= `MWM_RST_SPEED_BAND;
            speed_band_dwell_ms_r  <= `MWM_RST_SPEED_BAND_DWELL_MS;
            rdata_r                <= 32'h00000000;
            ack_r                  <= 1'b0;
            err_r                  <= 1'b0;
        end else begin
            lag_limit_r            <= lag_limit_nxt;
            lag_dwell_ms_r         <= lag_dwell_ms_nxt;
            target_band_r          <= target_band_nxt;
            target_band_dwell_ms_r <= target_band_dwell_ms_nxt;
            speed_band_r           <= speed_band_nxt;
            speed_band_dwell_ms_r  <= speed_band_dwell_ms_nxt;
            rdata_r                <= rdata_nxt;
            ack_r                  <= ack_nxt;
            err_r                  <= err_nxt;
        end
    end

    // ****************************************************************
    // Window comparisons
    // ****************************************************************
    logic tick;
    logic lag_cond;
    logic pos_cond;
    logic vel_cond;
    logic pos_mode;
    logic vel_mode;
    logic lag_met;
    logic pos_met;
    logic vel_met;

    mwm_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk  (clk),
        .rstn (rstn),
        .tick (tick)
    );

    // Mode qualifiers for bit 10
    assign pos_mode = (op_mode == `MWM_MODE_PROFILE_POS) ||
                      (op_mode == `MWM_MODE_INTERP_POS);
    assign vel_mode = (op_mode == `MWM_MODE_PROFILE_VEL);

    // Raw conditions; an all-ones lag limit or target band switches its monitor off
    assign lag_cond = (lag_limit_r != `MWM_WINDOW_OFF) &&
                      (abs_diff(drive.actual_position, drive.demand_position)
                       > lag_limit_r);
    assign pos_cond = pos_mode && (target_band_r != `MWM_WINDOW_OFF) &&
                      (abs_diff(drive.actual_position, drive.target_position)
                       < target_band_r);
    assign vel_cond = vel_mode &&
                      (abs_diff(drive.measured_speed, drive.set_speed)
                       < {16'h0000, speed_band_r});

    // Dwell qualifiers, each restarting when its condition drops
    mwm_dwell u_lag_dwell (
        .clk   (clk),
        .rstn  (rstn),
        .tick  (tick),
        .cond  (lag_cond),
        .limit (lag_dwell_ms_r),
        .met   (lag_met)
    );

    mwm_dwell u_pos_dwell (
        .clk   (clk),
        .rstn  (rstn),
        .tick  (tick),
        .cond  (pos_cond),
        .limit (target_band_dwell_ms_r),
        .met   (pos_met)
    );

    mwm_dwell u_vel_dwell (
        .clk   (clk),
        .rstn  (rstn),
        .tick  (tick),
        .cond  (vel_cond),
        .limit (speed_band_dwell_ms_r),
        .met   (vel_met)
    );

    // ****************************************************************
    // Status and reaction outputs
    // ****************************************************************
    logic [15:0] status_r,  status_nxt;
    logic        lag_d_r,   lag_d_nxt;
    logic        react_r,   react_nxt;
    logic        hist_r,    hist_nxt;
    logic [31:0] apos_r,    apos_nxt;
    logic [31:0] ramp_r,    ramp_nxt;
    logic [31:0] mspd_r,    mspd_nxt;

    // Reaction and history entry pulse on the rising edge of the lag flag
    always_comb begin
        status_nxt                        = 16'h0000;
        status_nxt[`MWM_SW_LAG_BIT]       = lag_met;
        status_nxt[`MWM_SW_TARGET_BIT]    = pos_met | vel_met;
        lag_d_nxt                         = lag_met;
        react_nxt = lag_met && !lag_d_r && (lag_reaction != 16'h0000);
        hist_nxt  = react_nxt;
        apos_nxt  = drive.actual_position;
        ramp_nxt  = drive.ramp_speed;
        mspd_nxt  = drive.measured_speed;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            status_r <= 16'h0000;
            lag_d_r  <= 1'b0;
            react_r  <= 1'b0;
            hist_r   <= 1'b0;
            apos_r   <= 32'h00000000;
            ramp_r   <= 32'h00000000;
            mspd_r   <= 32'h00000000;
        end else begin
            status_r <= status_nxt;
            lag_d_r  <= lag_d_nxt;
            react_r  <= react_nxt;
            hist_r   <= hist_nxt;
            apos_r   <= apos_nxt;
            ramp_r   <= ramp_nxt;
            mspd_r   <= mspd_nxt;
        end
    end

    assign obj_rdata         = rdata_r;
    assign obj_ack           = ack_r;
    assign obj_err           = err_r;
    assign status_bits       = status_r;
    assign lag_reaction_req  = react_r;
    assign history_log       = hist_r;
    assign actual_position   = apos_r;
    assign ramp_speed_output = ramp_r;
    assign measured_speed    = signed'(mspd_r);
endmodule : mwm_top
`default_nettype wire

/* mwm_top_sva.sv */
/* Port checker for the motion window monitor.
   Assumes a bind onto mwm_top and a single clock domain. */
`timescale 1ns/100ps
`default_nettype none
module mwm_top_sva
    import mwm_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire mwm_obj_req_s       obj_req,
    input  wire mwm_drive_s         drive,
    input  wire logic [7:0]         op_mode,
    input  wire logic [15:0]        lag_reaction,
    input  wire logic [31:0]        obj_rdata,
    input  wire logic               obj_ack,
    input  wire logic               obj_err,
    input  wire logic [15:0]        status_bits,
    input  wire logic               lag_reaction_req,
    input  wire logic               history_log,
    input  wire logic [31:0]        actual_position,
    input  wire logic [31:0]        ramp_speed_output,
    input  wire logic signed [31:0] measured_speed
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Object port answers one cycle after each strobe, never unprompted
    a_ack_follows_req: assert property ((obj_req.rd || obj_req.wr) |=> obj_ack)
        else $error("no ack after request");
    a_ack_has_cause: assert property (obj_ack |-> $past(obj_req.rd) || $past(obj_req.wr))
        else $error("ack without request");
    a_err_with_ack: assert property (obj_err |-> obj_ack)
        else $error("error without ack");
    a_ro_write_refused: assert property ( // Live objects refuse writes
        obj_req.wr && (obj_req.index inside {16'h6064, 16'h606B, 16'h606C}) |=> obj_err)
        else $error("read-only write accepted");
    // Live values are one-cycle copies; reset cycles are skipped via $past(rstn)
    a_speed_passthru: assert property ( // Measured speed copy
        $past(rstn) |-> measured_speed == $past(drive.measured_speed))
        else $error("measured speed not passed on");
    a_ramp_passthru: assert property ( // Ramp output copy
        $past(rstn) |-> ramp_speed_output == $past(drive.ramp_speed))
        else $error("ramp output not passed on");
    // Reaction pulse rides on the rising lag bit
    a_react_with_lag: assert property ( // Pulse on lag rise
        lag_reaction_req |-> status_bits[13] && !$past(status_bits[13]))
        else $error("reaction without lag rise");
    a_history_pairs: assert property (history_log == lag_reaction_req) // History too
        else $error("history and reaction differ");
    a_react_needs_cfg: assert property ( // Reaction configured
        lag_reaction_req |-> $past(lag_reaction) != 16'h0000)
        else $error("reaction without setting");
    a_spare_bits_zero: assert property ((status_bits & 16'hDBFF) == 16'h0000) // Bits
        else $error("unused status bit set");
endmodule : mwm_top_sva

bind mwm_top mwm_top_sva #(.TICK_CYCLES(TICK_CYCLES)) i_mwm_top_sva (
    .clk(clk), .rstn(rstn), .obj_req(obj_req), .drive(drive), .op_mode(op_mode),
    .lag_reaction(lag_reaction), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
    .obj_err(obj_err), .status_bits(status_bits), .lag_reaction_req(lag_reaction_req),
    .history_log(history_log), .actual_position(actual_position),
    .ramp_speed_output(ramp_speed_output), .measured_speed(measured_speed)
);
`default_nettype wire

/* mwm_master.sv */
/* Fieldbus master model issuing object reads and writes.
   Assumes one-cycle strobes answered by a one-cycle ack. */
`timescale 1ns/100ps
`default_nettype none
module mwm_master
    import mwm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       obj_ack,
    output var mwm_obj_req_s obj_req
);
    initial obj_req = '0;
    // ********
    // Access
    // ********
    // Strobe one cycle; idle fields get the inverse so stale data never passes
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk);
        obj_req <= '{wr: wr, rd: !wr, index: idx, wdata: wd};
        @(posedge clk);
        obj_req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, wdata: ~wd};
        @(posedge clk);
        while (obj_ack !== 1'b1 && k < 8) begin
            @(posedge clk);
            k++;
        end
    endtask : access
endmodule : mwm_master
`default_nettype wire

/* mwm_top_tb.sv */
/* Self-checking bench of mwm_top driven through the master model.
   Assumes a 50 MHz clock and a 10-cycle millisecond tick. */
`timescale 1ns/100ps
`default_nettype none
module mwm_top_tb
    import mwm_pkg::*;
;
    localparam int TK = 10;
    typedef struct packed {logic chk; logic [31:0] data; logic err;} mwm_note_s;
    logic               clk;
    logic               rstn;
    mwm_obj_req_s       obj_req;
    mwm_drive_s         drive;
    logic [7:0]         op_mode;
    logic [15:0]        lag_reaction;
    logic [31:0]        obj_rdata;
    logic [31:0]        actual_position;
    logic [31:0]        ramp_speed_output;
    logic               obj_ack;
    logic               obj_err;
    logic               lag_reaction_req;
    logic               history_log;
    logic [15:0]        status_bits;
    logic signed [31:0] measured_speed;
    logic [31:0]        rv;
    mwm_note_s          notes[$];
    mwm_note_s          nt;
    int                 n_errors = 0;
    int                 num_checks = 0;
    int                 n_react = 0;
    logic [15:0] idx_tab [9] = '{16'h6064, 16'h6065, 16'h6066, 16'h6067, 16'h6068,
                                 16'h606B, 16'h606C, 16'h606D, 16'h606E};
    logic [31:0] rst_tab [9] = '{32'h0, 32'h00000100, 32'h00000064, 32'h0000000A,
                                 32'h00000064, 32'h0, 32'h0, 32'h0000001E, 32'h0};
    logic [31:0] msk_tab [9] = '{32'h0, 32'hFFFFFFFF, 32'h0000FFFF, 32'hFFFFFFFF,
                                 32'h0000FFFF, 32'h0, 32'h0, 32'h0000FFFF, 32'h0000FFFF};

    mwm_top #(.TICK_CYCLES(TK)) i_mwm_top (
        .clk(clk), .rstn(rstn), .obj_req(obj_req), .drive(drive), .op_mode(op_mode),
        .lag_reaction(lag_reaction), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
        .obj_err(obj_err), .status_bits(status_bits), .lag_reaction_req(lag_reaction_req),
        .history_log(history_log), .actual_position(actual_position),
        .ramp_speed_output(ramp_speed_output), .measured_speed(measured_speed));
    mwm_master i_mwm_master (.clk(clk), .obj_ack(obj_ack), .obj_req(obj_req));

    // ********
    // Clock, compare and helpers
    // ********
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : check_word
    task automatic check_flag(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %b got %b", nm, e, g);
        end
    endtask : check_flag
    task automatic give_verdict();
        if (notes.size() != 0) n_errors++;
        if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // Note the expected answer, then issue; writes leave read data unchecked
    task automatic obj(input logic wr, input logic [15:0] ix, input logic [31:0] wd,
                       input logic [31:0] ed, input logic ee);
        notes.push_back('{chk: !wr, data: ed, err: ee});
        i_mwm_master.access(wr, ix, wd);
    endtask : obj
    task automatic cfg(input logic [15:0] ix, input logic [31:0] wd);
        obj(1'b1, ix, wd, 32'h0, 1'b0);
    endtask : cfg
    // Condition changed at the last edge: no early rise, then settle within bound
    task automatic dwell(input int b, input int lim, input logic e);
        int k;
        k = 0;
        if (e && lim > 0) begin
            repeat (lim * TK) @(posedge clk);
            #1 check_flag("dwell early", 1'b0, status_bits[b]);
        end
        if (e) while (status_bits[b] !== 1'b1 && k < (lim + 2) * TK + 4) begin
            @(posedge clk);
            #1 k++;
        end
        else repeat ((lim + 2) * TK + 4) @(posedge clk);
        #1 check_flag("dwell end", e, status_bits[b]);
    endtask : dwell

    // Answer watcher: oldest note against each ack
    always @(posedge clk) begin
        if (lag_reaction_req === 1'b1 || history_log === 1'b1) begin
            n_react++;
            check_flag("history_log", 1'b1, history_log);
        end
        if (obj_ack === 1'b1) begin
            nt = notes.pop_front();
            check_flag("obj_err", nt.err, obj_err);
            if (nt.chk) check_word("obj_rdata", nt.data, obj_rdata);
        end
    end
    // Hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    // ********
    // Main sequence
    // ********
    initial begin
        rstn = 1'b0;
        drive = '0;
        op_mode = 8'h00;
        lag_reaction = 16'h0001;
        void'($urandom(32'h7170));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 9; i++) obj(1'b0, idx_tab[i], 32'h0, rst_tab[i], 1'b0);
        for (int i = 0; i < 9; i++) begin
            rv = $urandom;
            obj(1'b1, idx_tab[i], rv, 32'h0, msk_tab[i] == 32'h0);
            if (msk_tab[i] != 32'h0) obj(1'b0, idx_tab[i], 32'h0, rv & msk_tab[i], 1'b0);
        end
        obj(1'b0, 16'h6069, 32'h0, 32'h0, 1'b1);
        obj(1'b1, 16'h6069, rv, 32'h0, 1'b1);
        // Live values follow the drive inputs
        @(posedge clk);
        drive <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        repeat (2) @(posedge clk);
        obj(1'b0, 16'h6064, 32'h0, drive.actual_position, 1'b0);
        obj(1'b0, 16'h606B, 32'h0, drive.ramp_speed, 1'b0);
        obj(1'b0, 16'h606C, 32'h0, drive.measured_speed, 1'b0);
        check_word("measured_speed", drive.measured_speed, measured_speed);
        check_word("actual_position", drive.actual_position, actual_position);
        check_word("ramp_speed_output", drive.ramp_speed, ramp_speed_output);
        @(posedge clk);
        drive <= '0;
        cfg(16'h6065, 32'h00000064);
        cfg(16'h6066, 32'h00000002);
        cfg(16'h6067, 32'hFFFFFFFF);
        cfg(16'h6068, 32'h00000003);
        repeat (4) @(posedge clk);
        n_react = 0;
        // Lag: equal to limit stays clear, beyond it rises after the lag dwell
        drive.actual_position <= 32'h00000064;
        dwell(13, 2, 1'b0);
        @(posedge clk);
        drive.actual_position <= 32'hFFFFFF9B;
        dwell(13, 2, 1'b1);
        repeat (2) @(posedge clk);
        check_word("reaction pulses", 32'h00000001, n_react);
        cfg(16'h6065, 32'hFFFFFFFF);
        dwell(13, 2, 1'b0);
        lag_reaction <= 16'h0000;
        cfg(16'h6065, 32'h00000064);
        dwell(13, 2, 1'b1);
        repeat (2) @(posedge clk);
        check_word("unset reaction", 32'h00000001, n_react);
        // Position: strict band, restart on a one-cycle dropout, modes, off value
        cfg(16'h6067, 32'h0000000A);
        @(posedge clk);
        op_mode <= 8'h01;
        drive.target_position <= 32'h000003E8;
        drive.actual_position <= 32'h000003F2;
        dwell(10, 3, 1'b0);
        @(posedge clk);
        drive.actual_position <= 32'h000003DF;
        repeat (2 * TK) @(posedge clk);
        drive.actual_position <= 32'h000003F2;
        @(posedge clk);
        drive.actual_position <= 32'h000003DF;
        dwell(10, 3, 1'b1);
        @(posedge clk);
        op_mode <= 8'h02;
        dwell(10, 3, 1'b0);
        @(posedge clk);
        op_mode <= 8'h07;
        dwell(10, 3, 1'b1);
        cfg(16'h6067, 32'hFFFFFFFF);
        dwell(10, 3, 1'b0);
        // Velocity: strict band at the upper edge, inside from below, zero and nonzero dwell
        cfg(16'h606D, 32'h0000001E);
        cfg(16'h606E, 32'h00000000);
        @(posedge clk);
        op_mode <= 8'h03;
        drive.set_speed <= 32'h000001F4;
        drive.measured_speed <= 32'h00000212;
        dwell(10, 0, 1'b0);
        @(posedge clk);
        drive.measured_speed <= 32'h000001D7;
        dwell(10, 0, 1'b1);
        @(posedge clk);
        drive.measured_speed <= 32'h00000212;
        cfg(16'h606E, 32'h00000002);
        @(posedge clk);
        drive.measured_speed <= 32'h0000020B;
        dwell(10, 2, 1'b1);
        repeat (2) @(posedge clk);
        give_verdict();
    end
endmodule : mwm_top_tb
`default_nettype wire
